// >>> design/bbx_pkg.sv
// Purpose: constants and types for the branch / bit-set / bit-test execute block
// Assumes: one clk edge per phase, four phases per instruction cycle
// Notes:   decoder and core both import this package
//
// Notes on behaviour
// - relative jump op: top 11010, 11-bit signed offset
// - jump target is incremented pc plus 2n
// - jump: pc written in phase four, then nop
// - bit force one sets one bit only
// - bit force one op: top nibble 1000
// - flag 0 access bank, 1 bank choice reg
// - flag 0, extended set, f<=5f: indexed offset
// - test skip on tested bit matching condition
// - skip discards prefetch, runs nop instead
`default_nettype none

package bbx_pkg;

  // ==========================================================
  // clocking
  // ==========================================================
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PHASES_PER_CYC  = 4;
  localparam int INSTR_CYC_NS    = CLK_PERIOD_NS * PHASES_PER_CYC;

  // ==========================================================
  // instruction fields
  // ==========================================================
  localparam int INSTR_W     = 16;
  localparam int NIB_HI      = 15;
  localparam int NIB_LO      = 12;
  localparam int JMP_TOP_LO  = 11;
  localparam int OFS_HI      = 10;
  localparam int OFS_W       = 11;
  localparam int BIT_HI      = 11;
  localparam int BIT_LO      = 9;
  localparam int ACC_POS     = 8;
  localparam int FILE_HI     = 7;
  localparam int FILE_W      = 8;
  localparam int ADDR_W      = 12;
  localparam int BANK_W      = 4;
  localparam int PC_W        = 21;

  localparam logic [4:0] JMP_TOP5       = 5'h1a;
  localparam logic [3:0] FORCE_ONE_NIB  = 4'h8;
  localparam logic [3:0] SKIP_ZERO_NIB  = 4'hb;
  localparam logic [3:0] SKIP_ONE_NIB   = 4'ha;

  // ==========================================================
  // addressing
  // ==========================================================
  localparam logic [7:0] IDX_LIMIT      = 8'h5f;
  localparam logic [7:0] ACC_SPLIT      = 8'h80;
  localparam logic [3:0] ACC_LOW_BANK   = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK  = 4'hf;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [11:0] ADDR_RST  = 12'h000;
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic [20:0] PC_RST    = 21'h000000;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } bbx_phase_e;

  typedef enum logic [0:0] {
    CY_EXEC  = 1'h0,
    CY_FLUSH = 1'h1
  } bbx_cycle_e;

  // ==========================================================
  // effective data address
  // ==========================================================
  function automatic logic [11:0] bbx_eff_addr(
    input logic       bankFlag,
    input logic [7:0] fileAddr,
    input logic       extSet,
    input logic [3:0] bankSel,
    input logic [11:0] idxBase
  );
    logic [11:0] ea;
    ea = {bankSel, fileAddr};
    if (!bankFlag) begin
      if (extSet && (fileAddr <= IDX_LIMIT)) begin
        ea = idxBase + {4'h0, fileAddr};
      end else if (fileAddr < ACC_SPLIT) begin
        ea = {ACC_LOW_BANK, fileAddr};
      end else begin
        ea = {ACC_HIGH_BANK, fileAddr};
      end
    end
    return ea;
  endfunction

endpackage

`default_nettype wire

// >>> design/bbx_dec_if.sv
// Purpose: carrier between instruction decoder and execute core
// Assumes: same clock domain on both sides
// Notes:   purely combinational signals
`default_nettype none

interface bbx_dec_if;
  logic [15:0] instr;
  logic        isJump;
  logic        isForceOne;
  logic        isSkipZero;
  logic        isSkipOne;
  logic [2:0]  bitSel;
  logic        bankFlag;
  logic [7:0]  fileAddr;
  logic [10:0] jumpOfs;

  modport dec (
    input  instr,
    output isJump, isForceOne, isSkipZero, isSkipOne, bitSel, bankFlag, fileAddr, jumpOfs
  );
  modport core (
    output instr,
    input  isJump, isForceOne, isSkipZero, isSkipOne, bitSel, bankFlag, fileAddr, jumpOfs
  );
endinterface

`default_nettype wire

// >>> design/bbx_decode.sv
// Purpose: field split and opcode match for the three handled instructions
// Assumes: instr holds the word latched in phase one
// Notes:   other opcodes match nothing and execute as no-ops here
`default_nettype none

module bbx_decode
  import bbx_pkg::*;
(
  bbx_dec_if.dec d
);

  // ==========================================================
  // opcode match
  // ==========================================================
  wire [3:0] topNib = d.instr[NIB_HI:NIB_LO];
  wire [4:0] top5   = d.instr[NIB_HI:JMP_TOP_LO];

  assign d.isJump     = (top5 == JMP_TOP5);
  assign d.isForceOne = (topNib == FORCE_ONE_NIB);
  assign d.isSkipZero = (topNib == SKIP_ZERO_NIB);
  assign d.isSkipOne  = (topNib == SKIP_ONE_NIB);

  // ==========================================================
  // fields
  // ==========================================================
  assign d.bitSel   = d.instr[BIT_HI:BIT_LO];
  assign d.bankFlag = d.instr[ACC_POS];
  assign d.fileAddr = d.instr[FILE_HI:0];
  assign d.jumpOfs  = d.instr[OFS_HI:0];

endmodule

`default_nettype wire

// >>> design/bbx_exec.sv
// Purpose: four-phase execute of relative jump, bit force one and bit test skip
// Assumes: fetch presents the next word in phase four; register file reads combinationally
// Notes:   status flags are never written by this block
`default_nettype none

module bbx_exec
  import bbx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  input  wire logic [20:0] pcIncr,
  input  wire logic        extSetEn,
  input  wire logic [3:0]  bankChoiceReg,
  input  wire logic [11:0] idxBase,
  input  wire logic [7:0]  rdData,
  output logic [1:0]       qPhase,
  output logic             cycleStart,
  output logic             rdEn,
  output logic [11:0]      rdAddr,
  output logic             wrEn,
  output logic [11:0]      wrAddr,
  output logic [7:0]       wrData,
  output logic             pcLoad,
  output logic [20:0]      pcNext,
  output logic             flushPrefetch,
  output logic             skipTaken
);

  // ==========================================================
  // state
  // ==========================================================
  bbx_phase_e  phase_r;
  bbx_phase_e  phase_nxt;
  bbx_cycle_e  cyc_r;
  bbx_cycle_e  cyc_nxt;
  logic [15:0] instr_r;
  logic        live_r;
  logic [11:0] ea_r;
  logic [7:0]  data_r;
  logic        rdEn_r;
  logic        wrEn_r;
  logic [7:0]  wrData_r;
  logic        pcLoad_r;
  logic [20:0] pcNext_r;
  logic        skip_r;

  // ==========================================================
  // decoder
  // ==========================================================
  bbx_dec_if decBus ();

  assign decBus.instr = instr_r;

  bbx_decode u_decode (
    .d (decBus)
  );

  // ==========================================================
  // phase sequencing
  // ==========================================================
  always_comb begin
    case (phase_r)
      PH_Q1:   phase_nxt = PH_Q2;
      PH_Q2:   phase_nxt = PH_Q3;
      PH_Q3:   phase_nxt = PH_Q4;
      PH_Q4:   phase_nxt = PH_Q1;
      default: phase_nxt = PH_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ==========================================================
  // qualified decode
  // ==========================================================
  wire inQ1     = (phase_r == PH_Q1);
  wire inQ2     = (phase_r == PH_Q2);
  wire inQ3     = (phase_r == PH_Q3);
  wire inQ4     = (phase_r == PH_Q4);
  wire doJump   = live_r && decBus.isJump;
  wire doForce  = live_r && decBus.isForceOne;
  wire doTest   = live_r && (decBus.isSkipZero || decBus.isSkipOne);
  wire needRead = doForce || doTest;

  // ==========================================================
  // effective address and arithmetic
  // ==========================================================
  wire [11:0] eaNow = bbx_eff_addr(decBus.bankFlag, decBus.fileAddr, extSetEn,
                                   bankChoiceReg, idxBase);

  // signed offset doubled and widened to pc width
  wire [20:0] ofsTwice = {{(PC_W - OFS_W - 1){decBus.jumpOfs[OFS_HI]}},
                          decBus.jumpOfs, 1'b0};
  wire [20:0] jumpTarget = pcIncr + ofsTwice;

  wire [7:0] bitMask   = 8'h01 << decBus.bitSel;
  wire [7:0] forced    = data_r | bitMask;
  wire       testedBit = |(data_r & bitMask);
  wire       skipHit   = (decBus.isSkipZero && !testedBit) ||
                         (decBus.isSkipOne && testedBit);

  // ==========================================================
  // cycle kind: normal execute or flushed no-op
  // ==========================================================
  always_comb begin
    cyc_nxt = cyc_r;
    if (inQ4) begin
      case (cyc_r)
        CY_EXEC: begin
          if (doJump || (doTest && skipHit)) begin
            cyc_nxt = CY_FLUSH;
          end else begin
            cyc_nxt = CY_EXEC;
          end
        end
        CY_FLUSH: cyc_nxt = CY_EXEC;
        default:  cyc_nxt = CY_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cyc_r <= CY_EXEC;
    end else begin
      cyc_r <= cyc_nxt;
    end
  end

  // ==========================================================
  // phase one: capture the word, or a no-op when flushing
  // ==========================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      instr_r <= INSTR_RST;
      live_r  <= 1'b0;
    end else if (inQ4) begin
      instr_r <= instrWord;
      live_r  <= instrValid && (cyc_nxt == CY_EXEC);
    end
  end

  // ==========================================================
  // phase two: read register f
  // ==========================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      rdEn_r <= 1'b0;
      ea_r   <= ADDR_RST;
    end else begin
      rdEn_r <= inQ1 && needRead;
      if (inQ1) begin
        ea_r <= eaNow;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_r <= DATA_RST;
    end else if (inQ2 && needRead) begin
      data_r <= rdData;
    end
  end

  // ==========================================================
  // phase three: process, phase four: write back
  // ==========================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      wrEn_r   <= 1'b0;
      wrData_r <= DATA_RST;
    end else begin
      wrEn_r <= inQ3 && doForce;
      if (inQ3 && doForce) begin
        wrData_r <= forced;
      end
    end
  end

  // ==========================================================
  // jump: write pc in phase four
  // ==========================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      pcLoad_r <= 1'b0;
      pcNext_r <= PC_RST;
    end else begin
      pcLoad_r <= inQ3 && doJump;
      if (inQ3 && doJump) begin
        pcNext_r <= jumpTarget;
      end
    end
  end

  // ==========================================================
  // skip decision, shown during phase four
  // ==========================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= inQ3 && doTest && skipHit;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign qPhase        = phase_r;
  assign cycleStart    = inQ1;
  assign rdEn          = rdEn_r;
  assign rdAddr        = ea_r;
  assign wrEn          = wrEn_r;
  assign wrAddr        = ea_r;
  assign wrData        = wrData_r;
  assign pcLoad        = pcLoad_r;
  assign pcNext        = pcNext_r;
  assign flushPrefetch = (cyc_r == CY_FLUSH);
  assign skipTaken     = skip_r;

endmodule

`default_nettype wire

// >>> verif/bbx_exec_asserts.sv
// Purpose: concurrent checks on the execute block ports
// Assumes: srst synchronous, one clk edge per phase
// Notes:   bound to every bbx_exec instance
`default_nettype none

module bbx_exec_asserts
  import bbx_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [20:0] pcIncr,
  input wire logic [7:0]  rdData,
  input wire logic [1:0]  qPhase,
  input wire logic        cycleStart,
  input wire logic        rdEn,
  input wire logic [11:0] rdAddr,
  input wire logic        wrEn,
  input wire logic [11:0] wrAddr,
  input wire logic [7:0]  wrData,
  input wire logic        pcLoad,
  input wire logic [20:0] pcNext,
  input wire logic        flushPrefetch,
  input wire logic        skipTaken
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // phase and pulse checks
  // ==========================================================
  AST_PHASE_WALK: assert property (qPhase == PH_Q1 |=> qPhase == PH_Q2 ##1
    qPhase == PH_Q3 ##1 qPhase == PH_Q4 ##1 qPhase == PH_Q1) else $error("phase order");
  AST_CYC_START: assert property (cycleStart == (qPhase == PH_Q1))
    else $error("cycle start");
  AST_READ_Q2: assert property (rdEn |-> qPhase == PH_Q2) else $error("read phase");
  AST_WRITE_BACK: assert property (wrEn |-> qPhase == PH_Q4 && $past(rdEn, 2)
    && wrAddr == $past(rdAddr, 2)) else $error("write back");
  AST_ONE_BIT: assert property (wrEn |-> (wrData & $past(rdData, 2)) == $past(rdData, 2)
    && $countones(wrData ^ $past(rdData, 2)) <= 1) else $error("bit set");
  AST_JUMP_Q4: assert property (pcLoad |-> qPhase == PH_Q4 && !wrEn && !skipTaken
    && pcNext[0] == $past(pcIncr[0])) else $error("jump load");
  AST_PC_HOLD: assert property (pcLoad |=> $stable(pcNext) [*3]) else $error("pc hold");
  AST_JUMP_FLUSH: assert property (pcLoad |=> flushPrefetch [*4] ##1 !flushPrefetch)
    else $error("jump flush");
  AST_SKIP_FLUSH: assert property (skipTaken |-> qPhase == PH_Q4 ##1 flushPrefetch [*4])
    else $error("skip flush");
  AST_FLUSH_QUIET: assert property (flushPrefetch |-> !(rdEn || wrEn || pcLoad || skipTaken))
    else $error("flush not quiet");
  AST_FLUSH_ALIGN: assert property ($rose(flushPrefetch) |-> qPhase == PH_Q1)
    else $error("flush align");
  cover property (pcLoad);
  cover property (skipTaken);
  cover property (wrEn);
endmodule

bind bbx_exec bbx_exec_asserts u_chk (.clk(clk), .srst(srst), .pcIncr(pcIncr),
  .rdData(rdData), .qPhase(qPhase), .cycleStart(cycleStart), .rdEn(rdEn), .rdAddr(rdAddr),
  .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .pcLoad(pcLoad), .pcNext(pcNext),
  .flushPrefetch(flushPrefetch), .skipTaken(skipTaken));

`default_nettype wire

// >>> verif/bbx_exec_test.sv
// Purpose: random and corner stimulus for the execute block
// Assumes: inputs driven on the falling edge
// Notes:   expectations come from the bench functions below
`default_nettype none

module bbx_exec_test
  import bbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, instrValid, extSetEn, curV, curF;
  logic        cycleStart, rdEn, wrEn, pcLoad, flushPrefetch, skipTaken;
  logic [15:0] instrWord, curW;
  logic [20:0] pcIncr, pcNext;
  logic [3:0]  bankChoiceReg;
  logic [11:0] idxBase, rdAddr, wrAddr;
  logic [7:0]  rdData, wrData;
  logic [1:0]  qPhase;
  logic [31:0] r;
  int          errors, compares, seed, i;
  bbx_phase_e  ph[4] = '{PH_Q1, PH_Q2, PH_Q3, PH_Q4};
  logic [3:0]  nibs[4] = '{4'h8, 4'ha, 4'hb, 4'hd};
  logic [15:0] cw[12] = '{16'hd400, 16'h8e5f, 16'hd3ff, 16'h8060, 16'h8e5f, 16'h8060,
                          16'h8280, 16'h8580, 16'hb0ff, 16'ha1ff, 16'hd800, 16'h8060};

  bbx_exec uut (.clk(clk), .srst(srst), .instrWord(instrWord), .instrValid(instrValid),
    .pcIncr(pcIncr), .extSetEn(extSetEn), .bankChoiceReg(bankChoiceReg), .idxBase(idxBase),
    .rdData(rdData), .qPhase(qPhase), .cycleStart(cycleStart), .rdEn(rdEn), .rdAddr(rdAddr),
    .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .pcLoad(pcLoad), .pcNext(pcNext),
    .flushPrefetch(flushPrefetch), .skipTaken(skipTaken));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t ns: %s wrong", $time, what);
    end
  endtask

  function automatic logic [11:0] expEa(input logic [15:0] w);
    if (w[8]) return {bankChoiceReg, w[7:0]};
    if (extSetEn && w[7:0] <= IDX_LIMIT) return idxBase + {4'h0, w[7:0]};
    return {(w[7] ? 4'hf : 4'h0), w[7:0]};
  endfunction

  task automatic seekQ4();
    int k;
    k = 0;
    while (qPhase !== PH_Q4 && k < 8) begin
      @(negedge clk);
      k++;
    end
    if (qPhase !== PH_Q4) begin
      errors++;
      $display("[ERR] %0t ns: phase four never reached", $time);
      conclude();
    end
  endtask

  task automatic rst();
    srst = 1'b1;
    repeat (16) @(negedge clk);
    chk(qPhase === PH_Q1 && {rdEn, wrEn, pcLoad, skipTaken, flushPrefetch} === 5'h0
        && pcNext === 21'h0 && {rdAddr, wrAddr, wrData} === 32'h0, "reset");
    srst = 1'b0;
    instrValid = 1'b0;
    curV = 1'b0;
    curF = 1'b0;
    seekQ4();
  endtask

  // one instruction cycle: check the word taken last cycle, present the next
  task automatic cyc(input logic [15:0] nw, input logic nv);
    logic jmp, frc, skz, sko, hit;
    int   k;
    jmp = curV && !curF && curW[15:11] == JMP_TOP5;
    frc = curV && !curF && curW[15:12] == FORCE_ONE_NIB;
    skz = curV && !curF && curW[15:12] == SKIP_ZERO_NIB;
    sko = curV && !curF && curW[15:12] == SKIP_ONE_NIB;
    hit = (skz && !rdData[curW[11:9]]) || (sko && rdData[curW[11:9]]);
    for (k = 0; k < 4; k++) begin
      @(negedge clk);
      chk(qPhase === ph[k] && cycleStart === (k == 0), "phase");
      chk(flushPrefetch === curF, "flush");
      chk(rdEn === (k == 1 && (frc || skz || sko)), "rdEn");
      if (k == 1 && (frc || skz || sko)) chk(rdAddr === expEa(curW), "rdAddr");
      chk(wrEn === (k == 3 && frc), "wrEn");
      chk(pcLoad === (k == 3 && jmp), "pcLoad");
      chk(skipTaken === (k == 3 && hit), "skipTaken");
    end
    if (frc) chk(wrData === (rdData | (8'h1 << curW[11:9]))
                 && wrAddr === expEa(curW), "wrData");
    if (jmp) chk(pcNext === pcIncr + {{9{curW[10]}}, curW[10:0], 1'b0}, "pcNext");
    curF = jmp || hit;
    curW = nw;
    curV = nv;
    instrWord = nw;
    instrValid = nv;
    r = $random(seed);
    rdData = r[7:0];
    bankChoiceReg = r[11:8];
    idxBase = r[23:12];
    extSetEn = r[24];
    r = $random(seed);
    pcIncr = {r[19:0], 1'b0};
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    seed = 32'h4227bf30;
    errors = 0;
    compares = 0;
    srst = 1'b1;
    instrWord = 16'h0000;
    instrValid = 1'b0;
    pcIncr = 21'h000000;
    extSetEn = 1'b0;
    bankChoiceReg = 4'h0;
    idxBase = 12'h000;
    rdData = 8'h00;
    curW = 16'h0000;
    rst();
    for (i = 0; i < 12; i++) cyc(cw[i], 1'b1);
    cyc(16'h8e5f, 1'b0);
    for (i = 0; i < 400; i++) begin
      if (i == 200) rst();
      r = $random(seed);
      r[15:12] = nibs[r[1:0]];
      cyc(r[15:0], r[31] | r[30]);
    end
    cyc(16'h0000, 1'b0);
    cyc(16'h0000, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
